// ---- include/pei_defines.vh ----
// Purpose: Shared constants for the event interrupt and configuration block.
// Assumes: AXI4-Lite with 32-bit data, byte address is four times the index.
// Notes: Definitions only.
`ifndef PEI_DEFINES_VH
`define PEI_DEFINES_VH
`define PEI_IDX_ENABLES 8'h12
`define PEI_IDX_FLAGS 8'h13
`define PEI_IDX_CONFIG 8'h14
`define PEI_IDX_CONTROL 8'h20
`define PEI_RST_ENABLES 16'h0000
`define PEI_RST_FLAGS 16'h0000
`define PEI_RST_CONFIG 16'h29C7
`define PEI_RST_CONTROL 16'h0000
`define PEI_RST_PIN 1'b1
`define PEI_RST_ATTEMPTS 4'h4
`define PEI_CFG_WMASK 16'hEFFF
`define PEI_CLR_ON_READ 16'hFDF1
`define PEI_BIT_DETECT 15
`define PEI_BIT_TXERR_SUP 14
`define PEI_BIT_POLARITY 13
`define PEI_BIT_SOFT_RST 12
`define PEI_BIT_ATT_HI 11
`define PEI_BIT_ATT_LO 10
`define PEI_BIT_DS_EN 9
`define PEI_BIT_DS_ENH 8
`define PEI_BIT_SER_AN 7
`define PEI_BIT_DS_10M 6
`define PEI_BIT_CLK_HI 5
`define PEI_BIT_CLK_LO 4
`define PEI_BIT_COL_FD 3
`define PEI_BIT_LEGACY 2
`define PEI_BIT_LSEMI 1
`define PEI_BIT_FSEMI 0
`define PEI_BIT_EEE 9
`define PEI_BIT_WAKE 3
`define PEI_BIT_MACBUF 2
`define PEI_BIT_POLCHG 1
`define PEI_RESP_OKAY 2'h0
`define PEI_RESP_SLVERR 2'h2
`endif

// ---- hw/pei_flag_bit.v ----
// Purpose: One event flag, latched high or live status.
// Assumes: Clear arrives as a one-cycle pulse on a flag register read.
// Notes: A set in the clear cycle wins.
`timescale 1ns/1ps
module pei_flag_bit #(
	parameter LATCHED = 1
) (
	input wire clock_in,
	input wire nrst_in,
	input wire event_in,
	input wire clear_in,
	output wire flag_out
);
	reg flag_r;
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			flag_r <= 1'b0;
		else if (LATCHED != 0)
			flag_r <= event_in | (flag_r & ~clear_in);
		else
			flag_r <= event_in;
	end
	assign flag_out = flag_r;
endmodule

// ---- hw/pei_top.v ----
// Purpose: Event flags, enables, interrupt pin and general configuration.
// Assumes: Event inputs are synchronous pulses or levels on clock_in.
// Notes: AXI4-Lite slave, one write and one read at a time.
//
// How it works
// - Flags set regardless of enable bits.
// - Enabled set flag drives the interrupt while control bit 0 is set.
// - Sixteen enables reset zero, MII gate too.
// - Bits 15,12,11 latch high, clear on read.
// - Bits 14,13,10 latch high, clear on read.
// - Bits 8,7 latch high, clear on read.
// - Bits 6,5,4 latch high, clear on read.
// - Bits 9,3 live status, read never clears.
// - Bit 2 shows MAC buffer fault.
// - Bit 1 latches polarity, bit 0 jabber.
// - Polarity bit 13 selects active low.
// - Config bit 12 gives self-clearing reset pulse.
// - Bit 14 suppresses serial transmit error.
// - Bits 11-10 pick 1,2,4,8 attempts.
// - Bit 9 enables downshift, resets off.
// - Bit 8 adds no-energy downshift.
// - Bit 6 allows fallback to 10M.
// - Bit 7 enables serial auto-negotiation.
// - Bits 5-4 select transmit clock rate.
// - Bit 3 drives collision in full duplex.
// - Bit 2 enables legacy scrambler selection.
// - Bits 1,0 enable leader/follower semi-cross.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pei_defines.vh"
module pei_top (
	input wire clock_in,
	input wire nrst_in,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] event_in,
	input wire serial_tx_error_in,
	input wire full_duplex_mode_in,
	input wire collision_in,
	output wire irq_pin_out,
	output wire serial_soft_reset_out,
	output wire serial_tx_error_out,
	output wire collision_out,
	output wire [3:0] downshift_attempt_count_out,
	output wire downshift_enable_out,
	output wire downshift_enhanced_enable_out,
	output wire downshift_to_10m_enable_out,
	output wire serial_negotiation_enable_out,
	output wire [1:0] tx_clock_select_out,
	output wire tx_clock_enable_out,
	output wire legacy_scrambler_auto_enable_out,
	output wire leader_semicross_enable_out,
	output wire follower_semicross_enable_out,
	output wire powered_device_detect_enable_out
);
	////////////////////////////////////////////////////////////////////////
	reg [15:0] enables_r;
	reg [15:0] config_r;
	reg [15:0] control_r;
	reg soft_rst_r;
	reg [31:0] awaddr_r;
	reg aw_full_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg w_full_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg irq_pin_r;
	reg [3:0] attempts_r;
	reg [3:0] attempts_nxt;
	reg tx_error_r;
	reg collision_r;
	wire [15:0] flags;
	wire [15:0] clear_vec;
	wire [15:0] wr_data16;
	wire [7:0] wr_idx;
	wire [7:0] rd_idx;
	wire do_write;
	wire do_read;
	wire wr_aligned;
	wire rd_aligned;
	wire flag_read;
	wire irq_any;
	wire [15:0] cfg_wmask;
	wire wr_hit_en;
	wire wr_hit_fl;
	wire wr_hit_cf;
	wire wr_hit_ct;
	wire wr_known;
	wire rd_hit_en;
	wire rd_hit_fl;
	wire rd_hit_cf;
	wire rd_hit_ct;
	wire collision_nxt;
	////////////////////////////////////////////////////////////////////////
	// Each flag is one instance; the clear pulse only reaches latched bits.
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1)
		begin : g_flag
			pei_flag_bit #(
				.LATCHED((gi == `PEI_BIT_EEE || gi == `PEI_BIT_WAKE || gi == `PEI_BIT_MACBUF) ? 0 : 1)
			) u_flag (
				.clock_in(clock_in),
				.nrst_in(nrst_in),
				.event_in(event_in[gi]),
				.clear_in(clear_vec[gi]),
				.flag_out(flags[gi])
			);
		end
	endgenerate
	assign clear_vec = flag_read ? `PEI_CLR_ON_READ : 16'h0000;
	////////////////////////////////////////////////////////////////////////
	// Address and data are held separately so either may arrive first.
	assign s_axi_awready = ~aw_full_r & ~bvalid_r;
	assign s_axi_wready = ~w_full_r & ~bvalid_r;
	assign do_write = aw_full_r & w_full_r & ~bvalid_r;
	assign wr_idx = awaddr_r[9:2];
	assign wr_aligned = (awaddr_r[1:0] == 2'h0) && (awaddr_r[31:10] == 22'h000000);
	assign wr_data16 = wdata_r[15:0];
	assign s_axi_arready = ~rvalid_r;
	assign do_read = s_axi_arvalid & ~rvalid_r;
	assign rd_idx = s_axi_araddr[9:2];
	assign rd_aligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[31:10] == 22'h000000);
	////////////////////////////////////////////////////////////////////////
	// One decode per register keeps the write response and the read mux in step.
	assign cfg_wmask = `PEI_CFG_WMASK;
	assign wr_hit_en = wr_aligned && (wr_idx == `PEI_IDX_ENABLES);
	assign wr_hit_fl = wr_aligned && (wr_idx == `PEI_IDX_FLAGS);
	assign wr_hit_cf = wr_aligned && (wr_idx == `PEI_IDX_CONFIG);
	assign wr_hit_ct = wr_aligned && (wr_idx == `PEI_IDX_CONTROL);
	assign wr_known = wr_hit_en | wr_hit_fl | wr_hit_cf | wr_hit_ct;
	assign rd_hit_en = rd_aligned && (rd_idx == `PEI_IDX_ENABLES);
	assign rd_hit_fl = rd_aligned && (rd_idx == `PEI_IDX_FLAGS);
	assign rd_hit_cf = rd_aligned && (rd_idx == `PEI_IDX_CONFIG);
	assign rd_hit_ct = rd_aligned && (rd_idx == `PEI_IDX_CONTROL);
	assign flag_read = do_read & rd_hit_fl;
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			awaddr_r <= 32'h00000000;
			aw_full_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			w_full_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `PEI_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				awaddr_r <= s_axi_awaddr;
				aw_full_r <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_full_r <= 1'b1;
			end
			if (do_write)
			begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				if (wr_known)
					bresp_r <= `PEI_RESP_OKAY;
				else
					bresp_r <= `PEI_RESP_SLVERR;
			end
			else if (bvalid_r & s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	////////////////////////////////////////////////////////////////////////
	// Register writes; the flag register ignores writes, reads clear all its bits but 9, 3, 2 and 1.
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			enables_r <= `PEI_RST_ENABLES;
			config_r <= `PEI_RST_CONFIG;
			control_r <= `PEI_RST_CONTROL;
			soft_rst_r <= 1'b0;
		end
		else
		begin
			soft_rst_r <= 1'b0;
			if (do_write && wr_aligned)
			begin
				if (wr_idx == `PEI_IDX_ENABLES)
				begin
					if (wstrb_r[0])
						enables_r[7:0] <= wr_data16[7:0];
					if (wstrb_r[1])
						enables_r[15:8] <= wr_data16[15:8];
				end
				if (wr_idx == `PEI_IDX_CONFIG)
				begin
					if (wstrb_r[0])
						config_r[7:0] <= wr_data16[7:0];
					if (wstrb_r[1])
						config_r[15:8] <= wr_data16[15:8] & cfg_wmask[15:8];
					if (wstrb_r[1] && wr_data16[`PEI_BIT_SOFT_RST])
						soft_rst_r <= 1'b1;
				end
				if (wr_idx == `PEI_IDX_CONTROL && wstrb_r[0])
					control_r <= {15'h0000, wr_data16[0]};
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Reads; the soft reset bit always reads back zero because the write mask never stores it.
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `PEI_RESP_OKAY;
		end
		else if (do_read)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= `PEI_RESP_OKAY;
			if (!rd_aligned)
			begin
				rdata_r <= 32'h00000000;
				rresp_r <= `PEI_RESP_SLVERR;
			end
			else if (rd_hit_en)
				rdata_r <= {16'h0000, enables_r};
			else if (rd_hit_fl)
				rdata_r <= {16'h0000, flags};
			else if (rd_hit_cf)
				rdata_r <= {16'h0000, config_r};
			else if (rd_hit_ct)
				rdata_r <= {16'h0000, control_r};
			else
			begin
				rdata_r <= 32'h00000000;
				rresp_r <= `PEI_RESP_SLVERR;
			end
		end
		else if (rvalid_r & s_axi_rready)
			rvalid_r <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	////////////////////////////////////////////////////////////////////////
	// Control bit 0 stands for the MII interrupt gate kept outside this map.
	assign irq_any = control_r[0] & (|(flags & enables_r));
	// The pin is a flop so that a polarity write cannot glitch it; it idles high out of reset.
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			irq_pin_r <= `PEI_RST_PIN;
		else if (config_r[`PEI_BIT_POLARITY])
			irq_pin_r <= ~irq_any;
		else
			irq_pin_r <= irq_any;
	end
	assign irq_pin_out = irq_pin_r;
	////////////////////////////////////////////////////////////////////////
	always @*
	begin
		case (config_r[`PEI_BIT_ATT_HI:`PEI_BIT_ATT_LO])
			2'h0: attempts_nxt = 4'h1;
			2'h1: attempts_nxt = 4'h2;
			2'h2: attempts_nxt = 4'h4;
			default: attempts_nxt = 4'h8;
		endcase
	end
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			attempts_r <= `PEI_RST_ATTEMPTS;
		else
			attempts_r <= attempts_nxt;
	end
	assign downshift_attempt_count_out = attempts_r;
	assign serial_soft_reset_out = soft_rst_r;
	// Both indications pass one flop: a cycle of delay traded for outputs free of glitches.
	assign collision_nxt = collision_in & (~full_duplex_mode_in | config_r[`PEI_BIT_COL_FD]);
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tx_error_r <= 1'b0;
			collision_r <= 1'b0;
		end
		else
		begin
			tx_error_r <= serial_tx_error_in & ~config_r[`PEI_BIT_TXERR_SUP];
			collision_r <= collision_nxt;
		end
	end
	assign serial_tx_error_out = tx_error_r;
	assign collision_out = collision_r;
	assign downshift_enable_out = config_r[`PEI_BIT_DS_EN];
	assign downshift_enhanced_enable_out = config_r[`PEI_BIT_DS_EN] & config_r[`PEI_BIT_DS_ENH];
	assign downshift_to_10m_enable_out = config_r[`PEI_BIT_DS_10M];
	assign serial_negotiation_enable_out = config_r[`PEI_BIT_SER_AN];
	assign tx_clock_select_out = config_r[`PEI_BIT_CLK_HI:`PEI_BIT_CLK_LO];
	assign tx_clock_enable_out = ~config_r[`PEI_BIT_CLK_HI];
	assign legacy_scrambler_auto_enable_out = config_r[`PEI_BIT_LEGACY];
	assign leader_semicross_enable_out = config_r[`PEI_BIT_LSEMI];
	assign follower_semicross_enable_out = config_r[`PEI_BIT_FSEMI];
	assign powered_device_detect_enable_out = config_r[`PEI_BIT_DETECT];
endmodule

// ---- testbench/pei_irq_consumer.sv ----
// Purpose: Host side consumer of the interrupt line.
// Assumes: The host knows the polarity it programmed.
// Notes: One register stage, as a host synchroniser adds.
`timescale 1ns/1ps
module pei_irq_consumer (
	input wire clock_in,
	input wire nrst_in,
	input wire active_low_in,
	input wire irq_pin_in,
	output reg irq_seen_out
);
	always @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			irq_seen_out <= 1'b0;
		else
			irq_seen_out <= irq_pin_in ^ active_low_in;
	end
endmodule

// ---- testbench/pei_monitor.sv ----
// Purpose: Port level checks of the event and configuration block.
// Assumes: Attached by bind to the top module.
// Notes: Configuration is seen only through its decoded outputs.
`timescale 1ns/1ps
module pei_monitor (
	input wire clock_in,
	input wire nrst_in,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire serial_tx_error_in,
	input wire serial_tx_error_out,
	input wire full_duplex_mode_in,
	input wire collision_in,
	input wire collision_out,
	input wire serial_soft_reset_out,
	input wire [3:0] downshift_attempt_count_out,
	input wire downshift_enable_out,
	input wire downshift_enhanced_enable_out,
	input wire [1:0] tx_clock_select_out,
	input wire tx_clock_enable_out,
	input wire irq_pin_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////
	a_att_onehot: assert property ($onehot(downshift_attempt_count_out))
		else $error("attempt count not 1, 2, 4 or 8");
	a_enh_gate: assert property (downshift_enhanced_enable_out |-> downshift_enable_out)
		else $error("enhanced downshift without downshift");
	a_clk_off: assert property (tx_clock_enable_out == !tx_clock_select_out[1])
		else $error("transmit clock enable wrong");
	a_soft_single: assert property (serial_soft_reset_out |=> !serial_soft_reset_out)
		else $error("soft reset longer than one cycle");
	a_col_half: assert property (!full_duplex_mode_in |=> collision_out == $past(collision_in))
		else $error("half duplex collision not passed");
	a_col_none: assert property (!collision_in |=> !collision_out)
		else $error("collision without cause");
	a_txerr_none: assert property (!serial_tx_error_in |=> !serial_tx_error_out)
		else $error("transmit error without cause");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	c_soft: cover property (serial_soft_reset_out);
	c_irq: cover property (!irq_pin_out);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ---- testbench/test_phy_event_interrupt_config.sv ----
// Purpose: Register and event tests of the event and configuration block.
// Assumes: AXI4-Lite byte address is four times the index.
// Notes: Live status bits are checked while their events are held.
`timescale 1ns/1ps
`include "pei_defines.vh"
module test_phy_event_interrupt_config;
	localparam [31:0] A_EN = `PEI_IDX_ENABLES * 4;
	localparam [31:0] A_FL = `PEI_IDX_FLAGS * 4;
	localparam [31:0] A_CF = `PEI_IDX_CONFIG * 4;
	localparam [31:0] A_CT = `PEI_IDX_CONTROL * 4;
	reg clock_in = 1'b0, nrst_in = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_tx_error_in = 1'b0, act_low = 1'b1, late_b = 1'b0;
	reg full_duplex_mode_in = 1'b0, collision_in = 1'b0;
	reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rv;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg [15:0] event_in = 16'h0000;
	reg [1:0] rr, br;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_pin_out, irq_seen;
	wire serial_soft_reset_out, serial_tx_error_out, collision_out, downshift_enable_out, tx_clock_enable_out;
	wire downshift_enhanced_enable_out, downshift_to_10m_enable_out, serial_negotiation_enable_out;
	wire legacy_scrambler_auto_enable_out, leader_semicross_enable_out, follower_semicross_enable_out;
	wire [1:0] s_axi_bresp, s_axi_rresp, tx_clock_select_out;
	wire [31:0] s_axi_rdata;
	wire [3:0] downshift_attempt_count_out;
	wire [9:0] modes = {downshift_enable_out, downshift_enhanced_enable_out, downshift_to_10m_enable_out,
		serial_negotiation_enable_out, tx_clock_select_out, tx_clock_enable_out,
		legacy_scrambler_auto_enable_out, leader_semicross_enable_out, follower_semicross_enable_out};
	integer errors = 0, compares = 0, pcnt = 0, base, i, n;
	pei_top dut (.clock_in, .nrst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in, .serial_tx_error_in,
		.full_duplex_mode_in, .collision_in, .irq_pin_out, .serial_soft_reset_out, .serial_tx_error_out,
		.collision_out, .downshift_attempt_count_out, .downshift_enable_out, .downshift_enhanced_enable_out,
		.downshift_to_10m_enable_out, .serial_negotiation_enable_out, .tx_clock_select_out, .tx_clock_enable_out,
		.legacy_scrambler_auto_enable_out, .leader_semicross_enable_out, .follower_semicross_enable_out,
		.powered_device_detect_enable_out());
	pei_irq_consumer host (.clock_in, .nrst_in, .active_low_in(act_low), .irq_pin_in(irq_pin_out),
		.irq_seen_out(irq_seen));
	////////////////////////////////////////
	initial forever #20 clock_in = ~clock_in;
	always @(posedge clock_in) if (serial_soft_reset_out === 1'b1) pcnt <= pcnt + 1;
	task print_verdict;
	begin
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		compares = compares + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	// A stuck handshake ends the wait after 50 cycles and counts as an error, without a compare or a MISMATCH line.
	task wr(input [31:0] a, input [15:0] d);
	begin
		@(posedge clock_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= ~late_b;
		n = 0;
		do
		begin
			@(posedge clock_in);
			n = n + 1;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
		end
		while ((s_axi_bvalid & s_axi_bready) !== 1'b1 && n < 50);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) errors = errors + 1;
	end
	endtask
	task rd(input [31:0] a);
	begin
		@(posedge clock_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_in);
			n = n + 1;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 50);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) errors = errors + 1;
	end
	endtask
	task ev(input [15:0] v);
	begin
		@(posedge clock_in);
		event_in <= v;
	end
	endtask
	task w(input integer k);
	begin
		repeat (k) @(posedge clock_in);
		#1;
	end
	endtask
	initial
	begin
		#400000;
		errors = errors + 1;
		print_verdict;
	end
	initial
	begin
		repeat (2) @(posedge clock_in);
		nrst_in <= 1'b1;
		w(1);
		chk("pin", 1, irq_pin_out);
		rd(A_EN);
		chk("enables", `PEI_RST_ENABLES, rv);
		rd(A_CF);
		chk("config", `PEI_RST_CONFIG, rv);
		chk("modes", 10'h0CF, modes);
		chk("attempts", 4, downshift_attempt_count_out);
		rd(32'h60);
		chk("resp", `PEI_RESP_SLVERR, rr);
		chk("data", 0, rv);
		late_b = 1'b1;
		wr(32'h60, 16'h0000);
		late_b = 1'b0;
		chk("bresp", `PEI_RESP_SLVERR, br);
		@(posedge clock_in);
		{serial_tx_error_in, full_duplex_mode_in, collision_in} <= 3'h7;
		w(1);
		chk("txerr", 1, serial_tx_error_out);
		chk("col", 0, collision_out);
		ev(16'hFFFF);
		ev(16'h0000);
		w(3);
		chk("pin", 1, irq_pin_out);
		rd(A_FL);
		chk("flags", 16'hFDF3, rv);
		wr(A_FL, 16'hFFFF);
		chk("bresp", `PEI_RESP_OKAY, br);
		rd(A_FL);
		chk("flags", 16'h0002, rv);
		ev(16'h020C);
		w(3);
		rd(A_FL);
		chk("flags", 16'h020E, rv);
		rd(A_FL);
		chk("flags", 16'h020E, rv);
		ev(16'h0000);
		w(3);
		rd(A_FL);
		chk("flags", 16'h0002, rv);
		wr(A_EN, 16'h0001);
		ev(16'h0001);
		ev(16'h0000);
		w(4);
		chk("irq", 0, irq_seen);
		rd(A_FL);
		wr(A_CT, 16'h0001);
		ev(16'h0002);
		ev(16'h0000);
		w(4);
		chk("irq", 0, irq_seen);
		rd(A_FL);
		ev(16'h0001);
		ev(16'h0000);
		w(4);
		chk("irq", 1, irq_seen);
		chk("pin", 0, irq_pin_out);
		w(4);
		chk("irq", 1, irq_seen);
		rd(A_FL);
		chk("flags", 16'h0003, rv);
		w(4);
		chk("irq", 0, irq_seen);
		wr(A_CF, 16'h09C7);
		act_low <= 1'b0;
		w(1);
		chk("pin", 0, irq_pin_out);
		ev(16'h0001);
		ev(16'h0000);
		w(4);
		chk("pin", 1, irq_pin_out);
		rd(A_FL);
		base = pcnt;
		wr(A_CF, 16'h39C7);
		act_low <= 1'b1;
		w(4);
		chk("pulses", 1, pcnt - base);
		rd(A_CF);
		chk("config", 16'h29C7, rv);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(A_CF, 16'h6338 | (i << 10));
			w(1);
			chk("attempts", 1 << i, downshift_attempt_count_out);
		end
		chk("modes", 10'h330, modes);
		chk("txerr", 0, serial_tx_error_out);
		chk("col", 1, collision_out);
		print_verdict;
	end
endmodule
bind pei_top pei_monitor mon (.clock_in, .nrst_in, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .serial_tx_error_in, .serial_tx_error_out, .full_duplex_mode_in, .collision_in,
	.collision_out, .serial_soft_reset_out, .downshift_attempt_count_out, .downshift_enable_out,
	.downshift_enhanced_enable_out, .tx_clock_select_out, .tx_clock_enable_out, .irq_pin_out);
